// >>> rtl/hbmpc_ctrl.sv
// H-bridge mode decode, sleep, undervoltage lockout and fault protection.
//
// Function
// - Inputs 1,0 select forward (sw a-high, b-low); 0,1 select reverse.
// - Inputs 0,0 turn all switches off; 1,1 brake both outputs low.
// - Continuous standby for the sleep time, about 10 ms, enters sleep.
// - Either control input going high leaves sleep and resumes decoding.
// - Below the falling supply threshold, ignore inputs and float outputs until above the rising one.
// - Over-current longer than the filter time turns all switches off.
// - After over-current, wait the retry time, then release protection.
// - Short detection per switch at 1.5x over-current, with no filter.
// - On a short, switches off, recheck every retry period until cleared.
// - Over-temperature holds switches off until below the recovery level.
// - Over-current filter time is typically 1.0 microseconds.
// - Protection retry time is typically 1.0 milliseconds.
`include "hbmpc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module hbmpc_ctrl #(
    parameter int RETRY_CYCLES =
        int'($ceil(`HBMPC_RETRY_TIME_MS * `HBMPC_US_PER_MS
                   * `HBMPC_CLOCK_MHZ)),
    parameter int SLEEP_CYCLES =
        int'($ceil(`HBMPC_SLEEP_TIME_MS * `HBMPC_US_PER_MS
                   * `HBMPC_CLOCK_MHZ))
) (
    input  wire logic   clock,
    input  wire logic   arst_n,
    input  wire logic   ctrl_in_a,
    input  wire logic   ctrl_in_b,
    input  wire logic   supply_above_rise,
    input  wire logic   supply_above_fall,
    input  wire logic   overcurrent_detect,
    input  wire logic [3:0] short_detect_sw,
    input  wire logic   thermal_trip,
    input  wire logic   thermal_recover,
    output logic        high_side_sw_a,
    output logic        low_side_sw_a,
    output logic        high_side_sw_b,
    output logic        low_side_sw_b,
    output logic        bridge_out_a_o,
    output logic        bridge_out_a_oe,
    output logic        bridge_out_b_o,
    output logic        bridge_out_b_oe,
    output logic        blocks_enabled,
    output logic        lockout_active,
    output logic        overcurrent_guard,
    output logic        short_guard,
    output logic        thermal_guard
);
    import hbmpc_pkg::*;

    // Over-current filter time rounds up to whole cycles.
    localparam int FILTER_CYCLES =
        int'($ceil(`HBMPC_FILTER_TIME_US * `HBMPC_CLOCK_MHZ));

    generate
        if (FILTER_CYCLES < 1 || RETRY_CYCLES < 1 || SLEEP_CYCLES < 1)
        begin : g_bad
            $error("hbmpc_ctrl timing counts must be at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timers.

    hbmpc_timer_if filt_tmr ();
    hbmpc_timer_if retry_tmr ();
    hbmpc_timer_if sleep_tmr ();

    hbmpc_timer #(.LIMIT(FILTER_CYCLES)) u_filter (
        .clock  (clock),
        .arst_n (arst_n),
        .tmr    (filt_tmr)
    );
    hbmpc_timer #(.LIMIT(RETRY_CYCLES)) u_retry (
        .clock  (clock),
        .arst_n (arst_n),
        .tmr    (retry_tmr)
    );
    hbmpc_timer #(.LIMIT(SLEEP_CYCLES)) u_sleep (
        .clock  (clock),
        .arst_n (arst_n),
        .tmr    (sleep_tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // State.

    hbmpc_prot_type   prot_q;
    hbmpc_switch_type sw_q;
    hbmpc_switch_type sw_d;
    logic             lockout_q;
    logic             therm_q;
    logic             sleep_q;
    logic             standby;
    logic             any_short;
    logic             force_off;

    assign standby   = !ctrl_in_a && !ctrl_in_b;
    assign any_short = |short_detect_sw;

    // Excess current must stand for the whole filter time.
    assign filt_tmr.run = overcurrent_detect && (prot_q == HBMPC_PROT_OK);
    // A held guard lets the timer wrap, so each expiry starts a new period.
    assign retry_tmr.run = (prot_q != HBMPC_PROT_OK);
    // Any input high clears the dwell count.
    assign sleep_tmr.run = standby && !sleep_q;

    // The lockout sets on a falling supply, and setting wins over release.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lockout_q <= `HBMPC_LOCKOUT_RST;
        end else if (!supply_above_fall) begin
            lockout_q <= 1'b1;
        end else if (supply_above_rise) begin
            lockout_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            therm_q <= 1'b0;
        end else if (thermal_trip) begin
            therm_q <= 1'b1;
        end else if (thermal_recover) begin
            therm_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sleep_q <= 1'b0;
        end else if (!standby) begin
            sleep_q <= 1'b0;
        end else if (sleep_tmr.done) begin
            sleep_q <= 1'b1;
        end
    end

    // A short outranks over-current at any time, even while retrying.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prot_q <= HBMPC_PROT_OK;
        end else begin
            case (prot_q)
                HBMPC_PROT_OK: begin
                    if (any_short) begin
                        prot_q <= HBMPC_PROT_SC_OFF;
                    end else if (filt_tmr.done) begin
                        prot_q <= HBMPC_PROT_OC_OFF;
                    end
                end
                HBMPC_PROT_OC_OFF: begin
                    if (any_short) begin
                        prot_q <= HBMPC_PROT_SC_OFF;
                    end else if (retry_tmr.done) begin
                        prot_q <= HBMPC_PROT_OK;
                    end
                end
                HBMPC_PROT_SC_OFF: begin
                    if (retry_tmr.done && !any_short) begin
                        prot_q <= HBMPC_PROT_OK;
                    end
                end
                default: begin
                    prot_q <= HBMPC_PROT_OK;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bridge decode.

    assign force_off = lockout_q || therm_q || sleep_q
                       || (prot_q != HBMPC_PROT_OK);

    always_comb begin
        sw_d = hbmpc_switch_type'(`HBMPC_SWITCH_RST);
        if (!force_off) begin
            case ({ctrl_in_a, ctrl_in_b})
                2'h2: begin
                    sw_d.hs_a = 1'b1;
                    sw_d.ls_b = 1'b1;
                end
                2'h1: begin
                    sw_d.ls_a = 1'b1;
                    sw_d.hs_b = 1'b1;
                end
                2'h3: begin
                    sw_d.ls_a = 1'b1;
                    sw_d.ls_b = 1'b1;
                end
                default: begin
                    sw_d = hbmpc_switch_type'(`HBMPC_SWITCH_RST);
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sw_q <= hbmpc_switch_type'(`HBMPC_SWITCH_RST);
        end else begin
            sw_q <= sw_d;
        end
    end

    assign high_side_sw_a    = sw_q.hs_a;
    assign low_side_sw_a     = sw_q.ls_a;
    assign high_side_sw_b    = sw_q.hs_b;
    assign low_side_sw_b     = sw_q.ls_b;
    assign bridge_out_a_o    = sw_q.hs_a;
    assign bridge_out_a_oe   = sw_q.hs_a || sw_q.ls_a;
    assign bridge_out_b_o    = sw_q.hs_b;
    assign bridge_out_b_oe   = sw_q.hs_b || sw_q.ls_b;
    assign blocks_enabled    = !sleep_q;
    assign lockout_active    = lockout_q;
    assign overcurrent_guard = (prot_q == HBMPC_PROT_OC_OFF);
    assign short_guard       = (prot_q == HBMPC_PROT_SC_OFF);
    assign thermal_guard     = therm_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic any_on;
    assign any_on = |sw_q;

    property p_forward;
        !force_off && ctrl_in_a && !ctrl_in_b
        |=> high_side_sw_a && low_side_sw_b && !low_side_sw_a
            && !high_side_sw_b;
    endproperty
    a_forward: assert property (p_forward)
        else $error("forward decode wrong");

    property p_reverse;
        !force_off && !ctrl_in_a && ctrl_in_b
        |=> low_side_sw_a && high_side_sw_b && !high_side_sw_a
            && !low_side_sw_b && bridge_out_b_o && !bridge_out_a_o;
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("reverse decode wrong");

    property p_standby_brake;
        (standby |=> !any_on && !bridge_out_a_oe && !bridge_out_b_oe)
        and (!force_off && ctrl_in_a && ctrl_in_b |=> sw_q == 4'h5);
    endproperty
    a_standby_brake: assert property (p_standby_brake)
        else $error("standby or brake decode wrong");

    property p_sleep_entry;
        $rose(sleep_q) |-> $past(standby, 1) && $past(sleep_tmr.done, 1);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep entered without full standby dwell");

    property p_wake;
        sleep_q && !standby |=> !sleep_q && blocks_enabled;
    endproperty
    a_wake: assert property (p_wake)
        else $error("sleep not left on input high");

    property p_lockout;
        !supply_above_fall |=> lockout_active ##1 !any_on;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("lockout did not force switches off");

    property p_ocp;
        prot_q == HBMPC_PROT_OK && !any_short
        && overcurrent_detect [*2] ##0 filt_tmr.done
        |=> overcurrent_guard ##1 !any_on;
    endproperty
    a_ocp: assert property (p_ocp)
        else $error("over-current did not trip after filter");

    property p_retry;
        overcurrent_guard && !any_short && retry_tmr.done
        |=> !overcurrent_guard && !short_guard;
    endproperty
    a_retry: assert property (p_retry)
        else $error("over-current not released at retry");

    property p_short;
        any_short |=> short_guard ##1 !any_on;
    endproperty
    a_short: assert property (p_short)
        else $error("short did not trip at once");

    property p_short_hold;
        short_guard && (any_short || !retry_tmr.done) |=> short_guard;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("short released before retry or while present");

    property p_thermal;
        thermal_guard && !thermal_recover |=> thermal_guard ##1 !any_on;
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("thermal hold released early");
endmodule
`default_nettype wire

// >>> rtl/hbmpc_map.svh
// Timing figures and reset values for the H-bridge mode and protection block.
`ifndef HBMPC_MAP_SVH
`define HBMPC_MAP_SVH

`define HBMPC_CLOCK_MHZ        10.0
`define HBMPC_FILTER_TIME_US   1.0
`define HBMPC_RETRY_TIME_MS    1.0
`define HBMPC_SLEEP_TIME_MS    10.0
`define HBMPC_US_PER_MS        1000.0
`define HBMPC_LOCKOUT_RST      1'h1
`define HBMPC_SWITCH_RST       4'h0

`endif

// >>> rtl/hbmpc_pkg.sv
// Types shared by the H-bridge mode and protection block.
package hbmpc_pkg;

    typedef enum logic [1:0] {
        HBMPC_PROT_OK,
        HBMPC_PROT_OC_OFF,
        HBMPC_PROT_SC_OFF
    } hbmpc_prot_type;

    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } hbmpc_switch_type;

endpackage

// >>> rtl/hbmpc_timer_if.sv
// Run and expiry handshake between the controller and one dwell timer.
`timescale 1ns/10ps
`default_nettype none
interface hbmpc_timer_if;
    logic run;
    logic done;
    modport ctrl  (output run, input done);
    modport timer (input run, output done);
endinterface
`default_nettype wire

// >>> rtl/hbmpc_timer.sv
// Dwell timer: counts while run is high, wraps at the limit, clears on stop.
`timescale 1ns/10ps
`default_nettype none
module hbmpc_timer #(
    parameter int LIMIT = 10
) (
    input  wire logic   clock,
    input  wire logic   arst_n,
    hbmpc_timer_if.timer tmr
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    logic [W-1:0] count_q;

    generate
        if (LIMIT < 1) begin : g_bad
            $error("hbmpc_timer LIMIT must be at least one");
        end
    endgenerate

    // Done pulses for one cycle at the limit and the count starts again,
    // so a timer left running gives a steady period of LIMIT+1 cycles.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (!tmr.run || count_q == LIM) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + W'(1);
        end
    end

    assign tmr.done = tmr.run && (count_q == LIM);
endmodule
`default_nettype wire

// >>> verification/hbmpc_host.sv
// Host-side model that drives the two bridge control inputs.
`timescale 1ns/10ps
`default_nettype none
module hbmpc_host (
    input  wire logic clock,
    output var logic  ctrl_in_a,
    output var logic  ctrl_in_b
);
    initial begin
        ctrl_in_a = 1'h0;
        ctrl_in_b = 1'h0;
    end

    // Inputs change just after a falling edge, away from the sampling edge.
    task automatic drive(input logic [1:0] mode);
        @(negedge clock);
        ctrl_in_a = mode[1];
        ctrl_in_b = mode[0];
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the H-bridge mode and protection block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import hbmpc_pkg::*;
    localparam int RETRY = 20;
    localparam int SLEEP = 40;
    logic       clock;
    logic       arst_n;
    logic       in_a;
    logic       in_b;
    logic       rise_ok;
    logic       fall_ok;
    logic       oc;
    logic [3:0] sc;
    logic       t_trip;
    logic       t_rec;
    wire  [3:0] sw;
    wire  [3:0] pins;
    wire  [4:0] st;
    int         error_cnt;
    int         total_checks;
    int         mode;

    hbmpc_host hbmpc_host_i (.clock(clock), .ctrl_in_a(in_a),
        .ctrl_in_b(in_b));

    hbmpc_ctrl #(.RETRY_CYCLES(RETRY), .SLEEP_CYCLES(SLEEP)) hbmpc_ctrl_i (
        .clock(clock), .arst_n(arst_n), .ctrl_in_a(in_a), .ctrl_in_b(in_b),
        .supply_above_rise(rise_ok), .supply_above_fall(fall_ok),
        .overcurrent_detect(oc), .short_detect_sw(sc),
        .thermal_trip(t_trip), .thermal_recover(t_rec),
        .high_side_sw_a(sw[3]), .low_side_sw_a(sw[2]),
        .high_side_sw_b(sw[1]), .low_side_sw_b(sw[0]),
        .bridge_out_a_oe(pins[3]), .bridge_out_a_o(pins[2]),
        .bridge_out_b_oe(pins[1]), .bridge_out_b_o(pins[0]),
        .blocks_enabled(st[4]), .lockout_active(st[3]),
        .overcurrent_guard(st[2]), .short_guard(st[1]),
        .thermal_guard(st[0]));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reference switch pattern {hs_a, ls_a, hs_b, ls_b} for a mode code.
    function automatic logic [3:0] exp_sw(input int m);
        case (m)
            2: exp_sw = 4'h9;
            1: exp_sw = 4'h6;
            3: exp_sw = 4'h5;
            default: exp_sw = 4'h0;
        endcase
    endfunction

    task automatic check_bridge(input bit off);
        logic [3:0] e;
        logic [3:0] p;
        e = off ? 4'h0 : exp_sw(mode);
        p = {e[3] | e[2], e[3], e[1] | e[0], e[1]};
        chk("switches", 8'(sw), 8'(e));
        chk("pins", 8'(pins), 8'(p));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic set_mode(input int m);
        mode = m;
        hbmpc_host_i.drive(2'(m));
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        error_cnt = 0;
        total_checks = 0;
        mode = 0;
        arst_n = 1'h0;
        rise_ok = 1'h0;
        fall_ok = 1'h1;
        oc = 1'h0;
        sc = 4'h0;
        t_trip = 1'h0;
        t_rec = 1'h1;
        void'($urandom(32'h3FABE0C1));
        cyc(4);
        arst_n = 1'h1;
        set_mode(2);
        chk("lockout", 8'(st[3]), 8'h01);
        check_bridge(1);
        rise_ok = 1'h1;
        cyc(3);
        check_bridge(0);
        fall_ok = 1'h0;
        cyc(3);
        check_bridge(1);
        fall_ok = 1'h1;
        cyc(3);
        check_bridge(0);
        $display("lockout test done");

        for (int i = 0; i < 16; i++) begin
            set_mode(i < 4 ? i : int'($urandom_range(3, 1)));
            check_bridge(0);
        end
        $display("mode test done");

        set_mode(2);
        oc = 1'h1;
        cyc(8);
        oc = 1'h0;
        cyc(2);
        chk("oc guard", 8'(st[2]), 8'h00);
        oc = 1'h1;
        cyc(14);
        oc = 1'h0;
        chk("oc guard", 8'(st[2]), 8'h01);
        check_bridge(1);
        cyc(RETRY - 6);
        chk("oc guard", 8'(st[2]), 8'h01);
        check_bridge(1);
        cyc(10);
        chk("oc guard", 8'(st[2]), 8'h00);
        check_bridge(0);
        $display("overcurrent test done");

        for (int b = 0; b < 4; b++) begin
            sc = 4'h1 << b;
            cyc(3);
            chk("short guard", 8'(st[1]), 8'h01);
            check_bridge(1);
            if (b == 0) begin
                cyc(RETRY + 6);
                check_bridge(1);
            end
            sc = 4'h0;
            cyc(RETRY + 6);
            chk("short guard", 8'(st[1]), 8'h00);
            check_bridge(0);
        end
        $display("short test done");

        t_trip = 1'h1;
        t_rec = 1'h0;
        cyc(3);
        check_bridge(1);
        t_trip = 1'h0;
        cyc(5);
        check_bridge(1);
        t_rec = 1'h1;
        cyc(3);
        chk("thermal guard", 8'(st[0]), 8'h00);
        check_bridge(0);
        $display("thermal test done");

        set_mode(0);
        cyc(SLEEP - 10);
        set_mode(2);
        set_mode(0);
        cyc(SLEEP - 10);
        chk("awake", 8'(st[4]), 8'h01);
        cyc(15);
        chk("awake", 8'(st[4]), 8'h00);
        mode = 1;
        hbmpc_host_i.drive(2'h1);
        cyc(1);
        chk("awake", 8'(st[4]), 8'h01);
        cyc(3);
        check_bridge(0);
        $display("sleep test done");
        end_sim();
    end
endmodule
`default_nettype wire
